// ==== logic/pin_mux_pkg.sv ====
package pin_mux_pkg;

   // ----------------------------------------------------------------
   // pad layout: indices 0..3 are port A bits 0..3, index 4 is bit 7
   // ----------------------------------------------------------------
   localparam int PAD_N = 5;
   localparam int A7_IDX = 4;
   localparam int MOD_PINS = 4;
   localparam int MOD_CHANNELS = 6;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int RESET_RELEASE_CYCLES = 32;

   // ----------------------------------------------------------------
   // configuration fields and reset values
   // ----------------------------------------------------------------
   localparam logic A7_GPIO_RESET = 1'b0;
   localparam logic [MOD_PINS-1:0] MOD_SEL_RESET = 4'h0;
   localparam logic [PAD_N-1:0] DIR_RESET = 5'h00;
   localparam logic [PAD_N-1:0] DOUT_RESET = 5'h00;
   localparam logic [PAD_N-1:0] SYNC_RESET = 5'h1f;

   typedef struct packed {
      logic a7_gpio;
      logic [MOD_PINS-1:0] mod_sel;
      logic [PAD_N-1:0] dir;
      logic [PAD_N-1:0] dout;
   } pin_cfg_t;

   typedef struct packed {
      logic [PAD_N-1:0] oe;
      logic [PAD_N-1:0] dout;
      logic [PAD_N-1:0] pull_up;
   } pad_drive_t;

   localparam pin_cfg_t CFG_RESET = '{A7_GPIO_RESET, MOD_SEL_RESET, DIR_RESET, DOUT_RESET};

endpackage

// ==== logic/reset_release.sv ====
`timescale 1ns/1ns
module reset_release
   import pin_mux_pkg::*;
#(
   parameter int RELEASE = RESET_RELEASE_CYCLES,
   parameter int CNT_W = $clog2(RELEASE + 1)
) (
   input wire logic clk, // system clock
   input wire logic resetn, // power-on reset, synchronous, active low
   input wire logic req, // combined reset request, active high
   output logic rst_n // internal chip reset, active low
);

   localparam logic [CNT_W-1:0] LAST = CNT_W'(RELEASE - 1);

   logic [CNT_W-1:0] cnt_reg;
   logic rst_n_reg;

   // ----------------------------------------------------------------
   // hold reset while requested, then count before releasing
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_reg <= '0;
         rst_n_reg <= 1'b0;
      end else if (req) begin // R2
         cnt_reg <= '0;
         rst_n_reg <= 1'b0;
      end else if (!rst_n_reg) begin
         if (cnt_reg == LAST) begin
            rst_n_reg <= 1'b1; // R3
         end else begin
            cnt_reg <= cnt_reg + CNT_W'(1); // R11
         end
      end
   end

   assign rst_n = rst_n_reg;

   AST_REQ_HOLDS: assert property (@(posedge clk) disable iff (!resetn) // R2
      req |=> !rst_n_reg)
      else $error("reset request did not hold internal reset");

   AST_RELEASE_COUNT: assert property (@(posedge clk) disable iff (!resetn) // R3
      $rose(rst_n_reg) |-> ($past(cnt_reg) == LAST) && !$past(req))
      else $error("internal reset released before the full count");

   AST_RELEASE_STEP: assert property (@(posedge clk) disable iff (!resetn) // R3
      (!rst_n_reg && !req && cnt_reg != LAST) |=> !rst_n_reg)
      else $error("internal reset released early");

endmodule

// ==== logic/reset_pin_and_port_a_mux.sv ====
//Contract
//R1: after reset every pin is in its primary function and alternates need a software write.
//R2: while the shared pin is in its reset role, driving it low resets and holds the chip.
//R3: internal reset is released on the clock, only after a fixed count of cycles.
//R4: in its port A bit 7 role the shared pin is an input or open-drain output, never push-pull.
//R5: in its port A bit 7 role the pin is no reset source; only power-on, watchdog or soft reset act.
//R6: after any reset the shared pin returns to its reset-input role.
//R7: each port A pin has its own direction control.
//R8: port A bits 0 to 3 can each carry one of the six modulator outputs, output only; here bit i carries only channel i, so channels 4 and 5 never reach a pin.
//R9: after reset port A bits 0 to 3 are general-purpose pins, not modulator outputs.
//R10: during reset every pin is an input with pull-up and nothing is driven.
//R11: the reset release count is a design parameter.
`timescale 1ns/1ns
module reset_pin_and_port_a_mux
   import pin_mux_pkg::*;
#(
   parameter int RELEASE = RESET_RELEASE_CYCLES
) (
   input wire logic clk, // 10 MHz system clock
   input wire logic resetn, // power-on reset, synchronous, active low
   input wire logic watchdog_reset, // watchdog reset request, active high
   input wire logic soft_reset, // software reset request, active high
   input wire logic cfg_we, // one-cycle strobe: load cfg_in
   input wire pin_cfg_t cfg_in, // new pin configuration
   input wire logic [MOD_CHANNELS-1:0] modulator_out, // modulator channel outputs
   input wire logic [PAD_N-1:0] pad_in, // pad input levels, asynchronous
   output pad_drive_t pads, // pad output, enable and pull-up
   output logic [PAD_N-1:0] pin_in, // synchronised pad levels
   output pin_cfg_t cfg_state, // current configuration
   output logic chip_reset_n // internal chip reset, active low
);

   // ----------------------------------------------------------------
   // pad input synchronisers
   // ----------------------------------------------------------------
   logic [PAD_N-1:0] sync1_reg;
   logic [PAD_N-1:0] sync2_reg;

   // idle high matches the pull-up, so the reset pin does not look asserted
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_reg <= SYNC_RESET;
         sync2_reg <= SYNC_RESET;
      end else begin
         sync1_reg <= pad_in;
         sync2_reg <= sync1_reg;
      end
   end

   assign pin_in = sync2_reg;

   // ----------------------------------------------------------------
   // reset request and release
   // ----------------------------------------------------------------
   pin_cfg_t cfg_reg;
   pin_cfg_t cfg_next;
   logic chip_rst_n;
   // any reset hands the shared pin back to its reset role, so a board that still
   // holds it low keeps the chip in reset until it lets go
   wire pin_reset_req = !cfg_reg.a7_gpio && !sync2_reg[A7_IDX]; // R2 R5
   wire reset_req = pin_reset_req || watchdog_reset || soft_reset; // R5

   reset_release #(
      .RELEASE(RELEASE)
   ) u_release (
      .clk(clk),
      .resetn(resetn),
      .req(reset_req),
      .rst_n(chip_rst_n)
   );

   assign chip_reset_n = chip_rst_n;

   // ----------------------------------------------------------------
   // configuration
   // ----------------------------------------------------------------
   // writes during internal reset are dropped: the defaults must win
   assign cfg_next = !chip_rst_n ? CFG_RESET : // R1 R6 R9
                     cfg_we ? cfg_in : cfg_reg;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_reg <= CFG_RESET; // R1 R9
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   assign cfg_state = cfg_reg;

   // ----------------------------------------------------------------
   // pad drive
   // ----------------------------------------------------------------
   logic [PAD_N-1:0] out_next;
   logic [PAD_N-1:0] oe_w;
   logic [PAD_N-1:0] dout_reg;

   genvar i;
   generate
      for (i = 0; i < MOD_PINS; i++) begin : g_mod_pin
         assign out_next[i] = cfg_reg.mod_sel[i] ? modulator_out[i] : cfg_reg.dout[i]; // R8
         // modulator selection forces output regardless of direction
         assign oe_w[i] = chip_rst_n && (cfg_reg.mod_sel[i] || cfg_reg.dir[i]); // R7 R8 R10

         AST_MOD_ROUTE: assert property (@(posedge clk) disable iff (!resetn) // R8
            (chip_rst_n && cfg_reg.mod_sel[i] && $past(chip_rst_n) && $past(cfg_reg.mod_sel[i]))
            |-> (pads.oe[i] && pads.dout[i] == $past(modulator_out[i])))
            else $error("modulator output not routed to its pin");

         AST_DIR: assert property (@(posedge clk) disable iff (!resetn) // R7
            (chip_rst_n && !cfg_reg.mod_sel[i]) |-> (pads.oe[i] == cfg_reg.dir[i]))
            else $error("pin enable does not follow its direction bit");

         AST_GPIO_DATA: assert property (@(posedge clk) disable iff (!resetn) // R7
            (chip_rst_n && $past(chip_rst_n) && !$past(cfg_reg.mod_sel[i]))
            |-> (pads.dout[i] == $past(cfg_reg.dout[i])))
            else $error("pin data does not follow its data bit");
      end
   endgenerate

   // open drain: only ever pulls low, the pad data is always zero
   assign out_next[A7_IDX] = 1'b0; // R4
   assign oe_w[A7_IDX] = chip_rst_n && cfg_reg.a7_gpio && cfg_reg.dir[A7_IDX]
                         && !cfg_reg.dout[A7_IDX]; // R4 R6 R10

   always_ff @(posedge clk) begin
      if (!resetn || !chip_rst_n) begin
         dout_reg <= '0; // R10
      end else begin
         dout_reg <= out_next;
      end
   end

   assign pads.dout = dout_reg;
   assign pads.oe = oe_w;
   assign pads.pull_up = ~oe_w; // R10

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_NO_DRIVE_IN_RESET: assert property (@(posedge clk) disable iff (!resetn) // R10
      !chip_rst_n |-> (pads.oe == '0 && pads.pull_up == '1))
      else $error("pin driven during reset");

   AST_CFG_DEFAULT: assert property (@(posedge clk) disable iff (!resetn) // R1
      (!chip_rst_n ##1 chip_rst_n) |-> (cfg_reg == CFG_RESET))
      else $error("configuration not at default after reset");

   AST_A7_BACK_TO_RESET: assert property (@(posedge clk) disable iff (!resetn) // R6
      (cfg_reg.a7_gpio && (watchdog_reset || soft_reset)) |=> ##1 !cfg_reg.a7_gpio)
      else $error("shared pin kept its port role after reset");

   AST_A7_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!resetn) // R4
      pads.oe[A7_IDX] |-> (pads.dout[A7_IDX] == 1'b0 && cfg_reg.a7_gpio
                           && !cfg_reg.dout[A7_IDX]))
      else $error("shared pin driven other than open drain");

   AST_A7_NOT_RESET: assert property (@(posedge clk) disable iff (!resetn) // R5
      (chip_rst_n && cfg_reg.a7_gpio && !watchdog_reset && !soft_reset) |=> chip_rst_n)
      else $error("shared pin in port role caused a reset");

   AST_PIN_RESET: assert property (@(posedge clk) disable iff (!resetn) // R2
      pin_reset_req |=> !chip_rst_n)
      else $error("low reset pin did not reset the chip");

   AST_MOD_DEFAULT: assert property (@(posedge clk) disable iff (!resetn) // R9
      !chip_rst_n |=> (cfg_reg.mod_sel == MOD_SEL_RESET))
      else $error("modulator selection survived reset");

   // ----------------------------------------------------------------
   // configuration, input path, reset and pad drive checks
   // ----------------------------------------------------------------
   // the chain is checked here because the outside only sees it two edges late
   AST_SYNC_DEPTH: assert property (@(posedge clk) disable iff (!resetn) // R2
      ($past(resetn) && $past(resetn, 2)) |-> (pin_in == $past(pad_in, 2)))
      else $error("pad level did not pass exactly two flops");

   AST_CFG_WRITE: assert property (@(posedge clk) disable iff (!resetn) // R1
      (chip_rst_n && cfg_we) |=> (cfg_reg == $past(cfg_in)))
      else $error("configuration write not taken");

   AST_CFG_KEEP: assert property (@(posedge clk) disable iff (!resetn) // R1
      (chip_rst_n && !cfg_we) |=> $stable(cfg_reg))
      else $error("configuration changed without a write");

   AST_A7_RESET_ROLE: assert property (@(posedge clk) disable iff (!resetn) // R6
      !chip_rst_n |=> !cfg_reg.a7_gpio)
      else $error("shared pin not back in its reset role");

   AST_A7_IGNORED: assert property (@(posedge clk) disable iff (!resetn) // R5
      cfg_reg.a7_gpio |-> !pin_reset_req)
      else $error("shared pin in port role seen as reset");

   AST_OTHER_SOURCES: assert property (@(posedge clk) disable iff (!resetn) // R5
      (watchdog_reset || soft_reset) |=> !chip_rst_n)
      else $error("watchdog or software reset ignored");

   AST_A7_RELEASED: assert property (@(posedge clk) disable iff (!resetn) // R4
      (cfg_reg.a7_gpio && cfg_reg.dout[A7_IDX]) |-> !pads.oe[A7_IDX])
      else $error("shared pin driven high");

   AST_RELEASE_QUIET: assert property (@(posedge clk) disable iff (!resetn) // R3
      $rose(chip_rst_n) |-> !$past(reset_req))
      else $error("internal reset released under a request");

   AST_PULL_UP: assert property (@(posedge clk) disable iff (!resetn) // R10
      pads.pull_up == ~pads.oe)
      else $error("pull-up not on for an undriven pin");

   COV_PIN_RESET: cover property (@(posedge clk) disable iff (!resetn)
      pin_reset_req ##1 !chip_rst_n);

   COV_A7_DRIVE_LOW: cover property (@(posedge clk) disable iff (!resetn)
      pads.oe[A7_IDX]);

   COV_MOD_ROUTE: cover property (@(posedge clk) disable iff (!resetn)
      chip_rst_n && cfg_reg.mod_sel != '0);

   COV_WATCHDOG_RELEASE: cover property (@(posedge clk) disable iff (!resetn)
      watchdog_reset ##[1:300] $rose(chip_rst_n));

   COV_SOFT_RELEASE: cover property (@(posedge clk) disable iff (!resetn)
      soft_reset ##[1:300] $rose(chip_rst_n));

endmodule

// ==== sim/pin_load_model.sv ====
`timescale 1ns/1ns
module pin_load_model
   import pin_mux_pkg::*;
(
   input wire pad_drive_t pads, // device pad drive
   input wire logic [PAD_N-1:0] pull_low, // board holds the pin low
   output logic [PAD_N-1:0] pad_in // resolved pad levels
);
   // ------------------------------------------------------------
   // pad resolution
   // ------------------------------------------------------------
   // a driven pad shows the device level, a released one the board or its pull-up
   assign pad_in = (pads.oe & pads.dout) | (~pads.oe & ~pull_low);
endmodule

// ==== sim/reset_pin_and_port_a_mux_tb.sv ====
`timescale 1ns/1ns
module reset_pin_and_port_a_mux_tb;
   import pin_mux_pkg::*;
   localparam int REL = 4;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic watchdog_reset = 1'b0;
   logic soft_reset = 1'b0;
   logic cfg_we = 1'b0;
   pin_cfg_t cfg_in = '0;
   pin_cfg_t cfg_state;
   pin_cfg_t c;
   logic [MOD_CHANNELS-1:0] modulator_out = '0;
   logic [PAD_N-1:0] pad_in;
   logic [PAD_N-1:0] pin_in;
   logic [PAD_N-1:0] pull_low = '0;
   pad_drive_t pads;
   logic chip_reset_n;
   int num_errors = 0;
   int checks = 0;
   int seed = 59;
   int i;
   logic [30:0] notes[$];
   event ev;

   always #50 clk = ~clk;

   reset_pin_and_port_a_mux #(.RELEASE(REL)) i_reset_pin_and_port_a_mux (.clk(clk),
      .resetn(resetn), .watchdog_reset(watchdog_reset), .soft_reset(soft_reset),
      .cfg_we(cfg_we), .cfg_in(cfg_in), .modulator_out(modulator_out), .pad_in(pad_in),
      .pads(pads), .pin_in(pin_in), .cfg_state(cfg_state), .chip_reset_n(chip_reset_n));
   pin_load_model i_pin_load_model (.pads(pads), .pull_low(pull_low), .pad_in(pad_in));

   // ------------------------------------------------------------
   // checking
   // ------------------------------------------------------------
   task automatic chk(logic [30:0] seen, logic [30:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic note(pin_cfg_t cf, pad_drive_t p, logic r);
      notes.push_back({r, cf, p});
      ->ev;
   endtask

   always begin
      @(ev);
      while (notes.size() > 0) chk({chip_reset_n, cfg_state, pads}, notes.pop_front());
   end

   task automatic results;
      $display("checks %0d, errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   function automatic pad_drive_t exp_pads(pin_cfg_t cf, logic [3:0] m);
      pad_drive_t p;
      p.oe[3:0] = cf.dir[3:0] | cf.mod_sel;
      p.oe[4] = cf.a7_gpio & cf.dir[4] & ~cf.dout[4];
      p.dout[3:0] = (cf.mod_sel & m) | (~cf.mod_sel & cf.dout[3:0]);
      p.dout[4] = 1'b0;
      p.pull_up = ~p.oe;
      return p;
   endfunction

   // ------------------------------------------------------------
   // driving
   // ------------------------------------------------------------
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask

   // bounded wait; a hang is reported and ends the run
   task automatic wait_rst(logic v);
      int k;
      for (k = 0; k < 20 && chip_reset_n !== v; k++) @(negedge clk);
      if (chip_reset_n !== v) begin
         num_errors++;
         $display("wrong value at %0t: reset wait ran out", $time);
         results();
      end
   endtask

   // pads.dout lands one edge after cfg_state, so wait two edges
   task automatic wr(pin_cfg_t cf);
      cfg_in = cf;
      cfg_we = 1'b1;
      @(negedge clk);
      cfg_we = 1'b0;
      cyc(1);
   endtask

   initial begin
      cyc(20);
      note('0, {5'h00, 5'h00, 5'h1f}, 1'b0);
      resetn = 1'b1;
      wr(15'($random(seed)));
      note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), 1'b0);
      cyc(REL - 3);
      note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), 1'b0);
      cyc(1);
      wait_rst(1'b1);
      note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), 1'b1);
      chk(31'(pin_in), 31'h1f);
      $display("test reset release done");
      for (i = 0; i < 4; i++) begin
         c = 15'($random(seed));
         c.a7_gpio = 1'b0;
         c.mod_sel = 4'h0;
         wr(c);
         note(c, exp_pads(c, 4'h0), 1'b1);
      end
      $display("test direction done");
      c.mod_sel = 4'hf;
      c.dir = 5'h00;
      wr(c);
      for (i = 0; i < 4; i++) begin
         modulator_out = 6'($random(seed));
         cyc(1);
         note(c, exp_pads(c, modulator_out[3:0]), 1'b1);
      end
      $display("test modulator done");
      c = '0;
      c.a7_gpio = 1'b1;
      c.dir = 5'h10;
      wr(c);
      pull_low[4] = 1'b1;
      cyc(REL + 5);
      note(c, exp_pads(c, 4'h0), 1'b1);
      chk(31'(pin_in), 31'h0f);
      c.dout[4] = 1'b1;
      wr(c);
      note(c, exp_pads(c, 4'h0), 1'b1);
      cyc(2);
      note(c, exp_pads(c, 4'h0), 1'b1);
      chk(31'(pin_in), 31'h0f);
      $display("test shared pin port done");
      for (i = 0; i < 2; i++) begin
         wr(c);
         if (i == 0) watchdog_reset = 1'b1;
         else soft_reset = 1'b1;
         cyc(1);
         watchdog_reset = 1'b0;
         soft_reset = 1'b0;
         cyc(1);
         note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), 1'b0);
         cyc(REL + 2);
         note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), !pull_low[4]);
         pull_low[4] = 1'b0;
         wait_rst(1'b1);
      end
      $display("test watchdog and soft reset done");
      pull_low[4] = 1'b1;
      cyc(2);
      note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), 1'b1);
      cyc(1);
      note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), 1'b0);
      cyc(REL + 4);
      note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), 1'b0);
      pull_low[4] = 1'b0;
      cyc(REL + 1);
      note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), 1'b0);
      cyc(1);
      wait_rst(1'b1);
      note(CFG_RESET, exp_pads(CFG_RESET, 4'h0), 1'b1);
      $display("test pin reset done");
      cyc(2);
      results();
   end
endmodule
